// ==== deic_host_model.sv ====
/*
 * Host model: resolves the routed interrupt pin and reports what the host sees.
 * Assumes a pull-up on the pin, so an undriven pin reads high.
 */
`timescale 1ns/10ps
module deic_host_model #(
  parameter int unsigned NPIN = 4
) (
  // Pins from the device
  input wire logic [NPIN-1:0] gpio_out,
  input wire logic [NPIN-1:0] gpio_oe,
  // Host setup
  input wire logic [1:0] pin_sel,
  input wire logic active_high,
  // Result
  output logic irq_seen
);
  logic level;
  // Released pin floats to the pull-up, never to the last driven value
  assign level = gpio_oe[pin_sel] ? gpio_out[pin_sel] : 1'b1;
  assign irq_seen = (level == active_high);
endmodule : deic_host_model

// ==== deic_lane_irq.sv ====
/*
 * Lane-processing interrupt controller: latches every per-lane event rise ungated,
 * gates the rises by type enables and lane select into a sticky summary.
 * Assumes lane events arrive already reordered to logical lanes, on clk.
 */
`timescale 1ns/10ps
module deic_lane_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Events, bit lane*LANE_TYPES+type
  input wire logic [deic_pkg::LANE_BITS-1:0] lane_events,
  // Controls
  input wire logic [deic_pkg::LANE_TYPES-1:0] type_enable,
  input wire deic_pkg::deic_lsel_t lane_select,
  input wire logic flag_reset,
  input wire logic summary_reset,
  // Results
  output logic [deic_pkg::LANE_BITS-1:0] lane_flags,
  output logic lane_event_summary
);
  typedef struct packed {
    logic [deic_pkg::LANE_BITS-1:0] prev;
    logic [deic_pkg::LANE_BITS-1:0] flags;
    logic summary;
  } deic_lane_state_t;

  deic_lane_state_t s_reg;
  deic_lane_state_t s_next;
  logic [deic_pkg::LANES-1:0] lane_use;
  logic [deic_pkg::LANES-1:0] lane_hit;
  logic [deic_pkg::LANE_BITS-1:0] rise;

  always_comb begin
    unique case (lane_select)
      deic_pkg::LSEL_LANE0: lane_use = 4'b0001;
      deic_pkg::LSEL_LANE1: lane_use = 4'b0010;
      deic_pkg::LSEL_LANE2: lane_use = 4'b0100;
      deic_pkg::LSEL_LANE3: lane_use = 4'b1000;
      deic_pkg::LSEL_LANE02: lane_use = 4'b0101;
      deic_pkg::LSEL_ALL: lane_use = 4'b1111;
      deic_pkg::LSEL_HOLD: lane_use = 4'b0000;
      deic_pkg::LSEL_NONE: lane_use = 4'b0000;
    endcase
  end

  assign rise = lane_events & ~s_reg.prev;

  // Logical lane index, not the physical input, picks the slice
  for (genvar l = 0; l < deic_pkg::LANES; l++) begin : g_lane
    assign lane_hit[l] = lane_use[l] &
      (|(rise[l*deic_pkg::LANE_TYPES +: deic_pkg::LANE_TYPES] & type_enable));
  end

  always_comb begin
    s_next = s_reg;
    s_next.prev = lane_events;
    // New rises win over a clear in the same cycle
    s_next.flags = (flag_reset ? '0 : s_reg.flags) | rise;
    // Hold mode, like none, adds no hits; summary_reset still clears the summary
    s_next.summary = (summary_reset ? 1'b0 : s_reg.summary) | (|lane_hit);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lane_flags = s_reg.flags;
  assign lane_event_summary = s_reg.summary;

  a_none_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    (lane_select inside {deic_pkg::LSEL_NONE, deic_pkg::LSEL_HOLD}) && !summary_reset
      |=> lane_event_summary == $past(lane_event_summary))
    else $error("lane summary changed with no lane selected");
endmodule : deic_lane_irq

// ==== deic_pkg.sv ====
/*
 * Shared constants for the DAC event interrupt controller: register map,
 * field positions, event numbering and lane select modes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package deic_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EN_LOW = 8'h04;
  localparam logic [7:0] OFF_EN_HIGH = 8'h08;
  localparam logic [7:0] OFF_FLAG_LOW = 8'h0C;
  localparam logic [7:0] OFF_FLAG_HIGH = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_DRIFT = 8'h18;
  localparam logic [7:0] OFF_LANE_SEL = 8'hE0;
  localparam logic [7:0] OFF_LANE_EN = 8'hE4;
  localparam logic [7:0] OFF_LANE_FLAGS = 8'hE8;
  localparam logic [7:0] OFF_LANE_RST = 8'hEC;
  localparam logic [7:0] OFF_LANE_SUM = 8'hF0;
  localparam int unsigned ADDR_W = 8;

  // Control and drift register fields
  localparam int unsigned CTRL_RST_BIT = 0;
  localparam int unsigned CTRL_POL_BIT = 1;
  localparam int unsigned CTRL_PINEN_BIT = 2;
  localparam int unsigned CTRL_PINSEL_LSB = 4;
  localparam int unsigned PINSEL_W = 2;
  localparam int unsigned DRIFT_W = 8;
  localparam int unsigned DRIFT_HI_LSB = 8;
  localparam logic [7:0] DRIFT_LO_RST = 8'h00;
  localparam logic [7:0] DRIFT_HI_RST = 8'hFF;

  // Main event numbering
  localparam int unsigned EV_N = 10;
  localparam int unsigned EV_LOW_W = 8;
  localparam int unsigned EV_HIGH_W = 2;
  localparam int unsigned EV_LANE = 0;
  localparam int unsigned EV_SYNC_START = 1;
  localparam int unsigned EV_SYNC_END = 2;
  localparam int unsigned EV_TEMP = 3;
  localparam int unsigned EV_LEVEL = 4;
  localparam int unsigned EV_LANE_CLK = 5;
  localparam int unsigned EV_DIV_CLK = 6;
  localparam int unsigned EV_DRIFT = 7;
  localparam int unsigned EV_ERR_RPT = 8;
  localparam int unsigned EV_MUTE = 9;

  // Lane monitor geometry
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_TYPES = 8;
  localparam int unsigned LANE_BITS = LANES * LANE_TYPES;

  typedef enum logic [2:0] {
    LSEL_LANE0,
    LSEL_LANE1,
    LSEL_LANE2,
    LSEL_LANE3,
    LSEL_LANE02,
    LSEL_ALL,
    LSEL_HOLD,
    LSEL_NONE
  } deic_lsel_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : deic_pkg

// ==== deic_top.sv ====
/*
 * DAC event interrupt controller: edge-latched event flags, enables,
 * active-high irq_out with a polarity-programmable copy on an I/O pin, AXI4-Lite registers
 * and the lane-processing sub-controller.
 * Assumes all event inputs are synchronous to clk (digital clock domain).
 */
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module deic_top #(
  parameter int unsigned NPIN = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write address
  input wire logic [deic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [deic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device events
  input wire logic sync_ctrl_active,
  input wire logic temp_alarm,
  input wire logic level_detector_event,
  input wire logic lane_clock_fault,
  input wire logic divider_clock_fault,
  input wire logic [deic_pkg::DRIFT_W-1:0] digital_clock_measure,
  input wire logic error_report_sent_event,
  input wire logic auto_mute_alarm,
  // Logical lane events
  input wire logic [deic_pkg::LANE_BITS-1:0] lane_events,
  // Interrupt
  output logic irq_out,
  output logic [NPIN-1:0] gpio_out,
  output logic [NPIN-1:0] gpio_oe
);
  typedef struct packed {
    logic [deic_pkg::EV_N-1:0] ev_prev;
    logic [deic_pkg::EV_N-1:0] flags;
    logic [deic_pkg::EV_N-1:0] enable;
    logic pol;
    logic pin_en;
    logic [deic_pkg::PINSEL_W-1:0] pin_sel;
    logic [deic_pkg::DRIFT_W-1:0] drift_lo;
    logic [deic_pkg::DRIFT_W-1:0] drift_hi;
    deic_pkg::deic_lsel_t lane_sel;
    logic [deic_pkg::LANE_TYPES-1:0] lane_en;
    logic irq_rst;
    logic lane_rst;
    logic irq;
    logic [NPIN-1:0] pin_out;
    logic [NPIN-1:0] pin_oe;
    logic aw_full;
    logic w_full;
    logic [deic_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } deic_state_t;

  deic_state_t s_reg;
  deic_state_t s_next;
  logic [deic_pkg::EV_N-1:0] ev_level;
  logic [deic_pkg::EV_N-1:0] ev_set;
  logic [deic_pkg::LANE_BITS-1:0] lane_flags;
  logic lane_event_summary;
  logic drift_out;
  logic commit;
  logic [31:0] wmerge;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic any_flag;

  // Apply byte strobes to the current register image
  function automatic logic [31:0] deic_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : deic_merge

  deic_lane_irq u_lane (
    .clk(clk),
    .rst_b(rst_b),
    .lane_events(lane_events),
    .type_enable(s_reg.lane_en),
    .lane_select(s_reg.lane_sel),
    .flag_reset(s_reg.lane_rst),
    .summary_reset(s_reg.irq_rst),
    .lane_flags(lane_flags),
    .lane_event_summary(lane_event_summary)
  );

  assign drift_out = (digital_clock_measure < s_reg.drift_lo) ||
                     (digital_clock_measure > s_reg.drift_hi);

  always_comb begin
    ev_level = '0;
    ev_level[deic_pkg::EV_LANE] = lane_event_summary;
    ev_level[deic_pkg::EV_SYNC_START] = sync_ctrl_active;
    // Rising edge of the inverted level marks the end of activity
    ev_level[deic_pkg::EV_SYNC_END] = ~sync_ctrl_active;
    ev_level[deic_pkg::EV_TEMP] = temp_alarm;
    ev_level[deic_pkg::EV_LEVEL] = level_detector_event;
    ev_level[deic_pkg::EV_LANE_CLK] = lane_clock_fault;
    ev_level[deic_pkg::EV_DIV_CLK] = divider_clock_fault;
    ev_level[deic_pkg::EV_DRIFT] = drift_out;
    ev_level[deic_pkg::EV_ERR_RPT] = error_report_sent_event;
    ev_level[deic_pkg::EV_MUTE] = auto_mute_alarm;
  end

  assign ev_set = ev_level & ~s_reg.ev_prev & s_reg.enable;
  assign commit = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
  assign wmerge = s_reg.wdata;

  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    unique case (s_axi_araddr)
      deic_pkg::OFF_CTRL: begin
        rd_word[deic_pkg::CTRL_POL_BIT] = s_reg.pol;
        rd_word[deic_pkg::CTRL_PINEN_BIT] = s_reg.pin_en;
        rd_word[deic_pkg::CTRL_PINSEL_LSB +: deic_pkg::PINSEL_W] = s_reg.pin_sel;
      end
      deic_pkg::OFF_EN_LOW: rd_word[deic_pkg::EV_LOW_W-1:0] =
        s_reg.enable[deic_pkg::EV_LOW_W-1:0];
      deic_pkg::OFF_EN_HIGH: rd_word[deic_pkg::EV_HIGH_W-1:0] =
        s_reg.enable[deic_pkg::EV_N-1:deic_pkg::EV_LOW_W];
      deic_pkg::OFF_FLAG_LOW: rd_word[deic_pkg::EV_LOW_W-1:0] =
        s_reg.flags[deic_pkg::EV_LOW_W-1:0];
      deic_pkg::OFF_FLAG_HIGH: rd_word[deic_pkg::EV_HIGH_W-1:0] =
        s_reg.flags[deic_pkg::EV_N-1:deic_pkg::EV_LOW_W];
      deic_pkg::OFF_STATUS: begin
        rd_word[deic_pkg::EV_N-1:0] = ev_level;
        rd_word[deic_pkg::EV_N] = s_reg.irq;
      end
      deic_pkg::OFF_DRIFT: begin
        rd_word[deic_pkg::DRIFT_W-1:0] = s_reg.drift_lo;
        rd_word[deic_pkg::DRIFT_HI_LSB +: deic_pkg::DRIFT_W] = s_reg.drift_hi;
      end
      deic_pkg::OFF_LANE_SEL: rd_word[2:0] = s_reg.lane_sel;
      deic_pkg::OFF_LANE_EN: rd_word[deic_pkg::LANE_TYPES-1:0] = s_reg.lane_en;
      deic_pkg::OFF_LANE_FLAGS: rd_word = lane_flags;
      deic_pkg::OFF_LANE_RST: rd_word = '0;
      deic_pkg::OFF_LANE_SUM: rd_word[0] = lane_event_summary;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_hit = s_reg.aw_addr inside {deic_pkg::OFF_CTRL, deic_pkg::OFF_EN_LOW,
      deic_pkg::OFF_EN_HIGH, deic_pkg::OFF_FLAG_LOW, deic_pkg::OFF_FLAG_HIGH,
      deic_pkg::OFF_STATUS, deic_pkg::OFF_DRIFT, deic_pkg::OFF_LANE_SEL,
      deic_pkg::OFF_LANE_EN, deic_pkg::OFF_LANE_FLAGS, deic_pkg::OFF_LANE_RST,
      deic_pkg::OFF_LANE_SUM};
  end

  always_comb begin
    logic [31:0] img;
    img = '0;
    s_next = s_reg;
    s_next.ev_prev = ev_level;
    s_next.irq_rst = 1'b0;
    s_next.lane_rst = 1'b0;

    // Write channels, taken in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_full = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (commit) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = wr_hit ? deic_pkg::RESP_OKAY : deic_pkg::RESP_SLVERR;
      unique case (s_reg.aw_addr)
        deic_pkg::OFF_CTRL: begin
          img[deic_pkg::CTRL_POL_BIT] = s_reg.pol;
          img[deic_pkg::CTRL_PINEN_BIT] = s_reg.pin_en;
          img[deic_pkg::CTRL_PINSEL_LSB +: deic_pkg::PINSEL_W] = s_reg.pin_sel;
          img = deic_merge(img, wmerge, s_reg.wstrb);
          s_next.irq_rst = img[deic_pkg::CTRL_RST_BIT];
          s_next.pol = img[deic_pkg::CTRL_POL_BIT];
          s_next.pin_en = img[deic_pkg::CTRL_PINEN_BIT];
          s_next.pin_sel = img[deic_pkg::CTRL_PINSEL_LSB +: deic_pkg::PINSEL_W];
        end
        deic_pkg::OFF_EN_LOW: begin
          img[deic_pkg::EV_LOW_W-1:0] = s_reg.enable[deic_pkg::EV_LOW_W-1:0];
          img = deic_merge(img, wmerge, s_reg.wstrb);
          s_next.enable[deic_pkg::EV_LOW_W-1:0] = img[deic_pkg::EV_LOW_W-1:0];
        end
        deic_pkg::OFF_EN_HIGH: begin
          img[deic_pkg::EV_HIGH_W-1:0] = s_reg.enable[deic_pkg::EV_N-1:deic_pkg::EV_LOW_W];
          img = deic_merge(img, wmerge, s_reg.wstrb);
          s_next.enable[deic_pkg::EV_N-1:deic_pkg::EV_LOW_W] = img[deic_pkg::EV_HIGH_W-1:0];
        end
        deic_pkg::OFF_DRIFT: begin
          img[deic_pkg::DRIFT_W-1:0] = s_reg.drift_lo;
          img[deic_pkg::DRIFT_HI_LSB +: deic_pkg::DRIFT_W] = s_reg.drift_hi;
          img = deic_merge(img, wmerge, s_reg.wstrb);
          s_next.drift_lo = img[deic_pkg::DRIFT_W-1:0];
          s_next.drift_hi = img[deic_pkg::DRIFT_HI_LSB +: deic_pkg::DRIFT_W];
        end
        deic_pkg::OFF_LANE_SEL: begin
          img[2:0] = s_reg.lane_sel;
          img = deic_merge(img, wmerge, s_reg.wstrb);
          s_next.lane_sel = deic_pkg::deic_lsel_t'(img[2:0]);
        end
        deic_pkg::OFF_LANE_EN: begin
          img[deic_pkg::LANE_TYPES-1:0] = s_reg.lane_en;
          img = deic_merge(img, wmerge, s_reg.wstrb);
          s_next.lane_en = img[deic_pkg::LANE_TYPES-1:0];
        end
        deic_pkg::OFF_LANE_RST: begin
          img = deic_merge(img, wmerge, s_reg.wstrb);
          s_next.lane_rst = img[0];
        end
        default: begin
          // Read-only and unmapped words ignore the data
          img = '0;
        end
      endcase
    end
    s_next.awready = !s_next.aw_full;
    s_next.wready = !s_next.w_full;

    // Read channel: one outstanding read
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word;
      s_next.rresp = rd_hit ? deic_pkg::RESP_OKAY : deic_pkg::RESP_SLVERR;
    end
    s_next.arready = !s_next.rvalid;

    // Sticky flags; a new event beats the reset pulse
    s_next.flags = (s_reg.irq_rst ? '0 : s_reg.flags) | ev_set;
    s_next.irq = |s_next.flags;

    // Pin drive follows the polarity one cycle after the flag
    for (int p = 0; p < NPIN; p++) begin
      s_next.pin_oe[p] = s_reg.pin_en && (s_reg.pin_sel == p[deic_pkg::PINSEL_W-1:0]);
      s_next.pin_out[p] = s_next.pin_oe[p] && (s_reg.irq ^ !s_reg.pol);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.drift_lo <= deic_pkg::DRIFT_LO_RST;
      s_reg.drift_hi <= deic_pkg::DRIFT_HI_RST;
      s_reg.lane_sel <= deic_pkg::LSEL_NONE;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign any_flag = |s_reg.flags;
  assign irq_out = s_reg.irq;
  assign gpio_out = s_reg.pin_out;
  assign gpio_oe = s_reg.pin_oe;
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_flag_needs_enable: assert property (
    $rose(s_reg.flags[deic_pkg::EV_TEMP]) |-> $past(s_reg.enable[deic_pkg::EV_TEMP]))
    else $error("flag set without enable");
  a_temp_edge_flags: assert property (
    !s_reg.irq_rst && s_reg.enable[deic_pkg::EV_TEMP] && $rose(temp_alarm)
      |=> s_reg.flags[deic_pkg::EV_TEMP])
    else $error("enabled temperature edge not flagged");
  a_sync_end_flag: assert property (
    s_reg.enable[deic_pkg::EV_SYNC_END] && $fell(sync_ctrl_active)
      |=> s_reg.flags[deic_pkg::EV_SYNC_END])
    else $error("end of sync activity not flagged");
  a_reset_clears: assert property (
    s_reg.irq_rst && ev_set == '0 |=> s_reg.flags == '0 && !irq_out)
    else $error("reset bit did not clear flags and irq");
  a_irq_follows_flags: assert property (
    any_flag |-> irq_out)
    else $error("irq inactive while a flag is set");
  a_pin_polarity: assert property (
    (|gpio_oe)
      |-> ((|gpio_out) == ($past(irq_out) ^ !$past(s_reg.pol))))
    else $error("pin level does not match irq and polarity");
  a_write_answer: assert property (
    commit |=> $rose(s_axi_bvalid))
    else $error("write response missing");
  a_read_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_lane_sum_reset: assert property (
    s_reg.irq_rst && (u_lane.lane_hit == '0)
      |=> !lane_event_summary)
    else $error("lane summary not reinitialised");

  c_irq_raised: cover property ($rose(irq_out));
  c_irq_reset: cover property (s_reg.irq_rst && any_flag);
  c_lane_event: cover property ($rose(s_reg.flags[deic_pkg::EV_LANE]));
  c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == deic_pkg::RESP_SLVERR);
endmodule : deic_top

// ==== test_dac_event_interrupt_controller.sv ====
/*
 * Testbench for the event interrupt controller: register bus, events, pin, lanes.
 * Assumes deic_pkg and deic_top are compiled first, and the host model.
 */
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module test_dac_event_interrupt_controller;
  logic clk = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, gpio_out, gpio_oe;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out, seen;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, hsel = 2'h0;
  logic sync_ctrl_active = 1'b0, temp_alarm = 1'b0, level_detector_event = 1'b0;
  logic lane_clock_fault = 1'b0, divider_clock_fault = 1'b0, error_report_sent_event = 1'b0;
  logic auto_mute_alarm = 1'b0, hpol = 1'b0;
  logic [7:0] digital_clock_measure = 8'h15;
  logic [31:0] lane_events = 32'h0000_0000;
  logic [9:0] fl;
  int fails = 0, checked = 0;

  deic_top deic_top_i (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_ctrl_active, .temp_alarm,
    .level_detector_event, .lane_clock_fault, .divider_clock_fault, .digital_clock_measure,
    .error_report_sent_event, .auto_mute_alarm, .lane_events, .irq_out, .gpio_out, .gpio_oe);
  deic_host_model deic_host_model_i (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pin_sel(hsel), .active_high(hpol), .irq_seen(seen));

  always #2 clk = ~clk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic rdf;
    rdr(deic_pkg::OFF_FLAG_HIGH);
    fl[9:8] = rd[1:0];
    rdr(deic_pkg::OFF_FLAG_LOW);
    fl[7:0] = rd[7:0];
  endtask : rdf

  task automatic ev(input int i, input logic v);
    case (i)
      1: sync_ctrl_active <= v;
      3: temp_alarm <= v;
      4: level_detector_event <= v;
      5: lane_clock_fault <= v;
      6: divider_clock_fault <= v;
      7: digital_clock_measure <= v ? 8'h30 : 8'h15;
      8: error_report_sent_event <= v;
      default: auto_mute_alarm <= v;
    endcase
    repeat (3) @(posedge clk);
  endtask : ev

  task automatic t_reset;
    `CHK("irq_out", 1'b0, irq_out)
    `CHK("gpio_oe", 4'h0, gpio_oe)
    rdr(deic_pkg::OFF_DRIFT);
    `CHK("drift", 32'h0000_FF00, rd)
    rdr(deic_pkg::OFF_LANE_SEL);
    `CHK("lane_sel", 32'h0000_0007, rd)
    rdr(8'h40);
    `CHK("rresp", deic_pkg::RESP_SLVERR, rs)
    wr(8'h44, 32'h0000_0001);
    `CHK("bresp", deic_pkg::RESP_SLVERR, rs)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_edge;
    // Level already high when enabled must not count as a rise
    ev(3, 1'b1);
    wr(deic_pkg::OFF_EN_LOW, 32'h0000_0008);
    rdf();
    `CHK("flags", 10'h000, fl)
    ev(3, 1'b0);
    ev(3, 1'b1);
    ev(3, 1'b0);
    rdf();
    `CHK("flags", 10'h008, fl)
    `CHK("irq_out", 1'b1, irq_out)
    wr(deic_pkg::OFF_FLAG_LOW, 32'h0000_0000);
    `CHK("bresp", deic_pkg::RESP_OKAY, rs)
    rdf();
    `CHK("flags", 10'h008, fl)
    wr(deic_pkg::OFF_CTRL, 32'h0000_0001);
    rdf();
    `CHK("flags", 10'h000, fl)
    `CHK("irq_out", 1'b0, irq_out)
    $display("t_edge done");
  endtask : t_edge

  task automatic t_all;
    hsel = 2'h2;
    hpol = 1'b1;
    wr(deic_pkg::OFF_DRIFT, 32'h0000_2010);
    wr(deic_pkg::OFF_EN_LOW, 32'h0000_00FF);
    wr(deic_pkg::OFF_EN_HIGH, 32'h0000_0003);
    wr(deic_pkg::OFF_CTRL, 32'h0000_0027);
    for (int i = 1; i < 10; i++) begin
      if (i != 2) begin
        ev(i, 1'b1);
        rdf();
        `CHK("flags", 10'(1 << i), fl)
        `CHK("irq_seen", 1'b1, seen)
        ev(i, 1'b0);
        rdf();
        `CHK("flags", (i == 1) ? 10'h006 : 10'(1 << i), fl)
        wr(deic_pkg::OFF_CTRL, 32'h0000_0027);
        // Flags clear one edge after the answer, the pin one edge later
        repeat (2) @(posedge clk);
        `CHK("irq_seen", 1'b0, seen)
      end
    end
    // Active-low on pin 1: idle level is high
    hsel = 2'h1;
    hpol = 1'b0;
    wr(deic_pkg::OFF_CTRL, 32'h0000_0015);
    repeat (2) @(posedge clk);
    `CHK("gpio_out", 4'h2, gpio_out)
    `CHK("gpio_oe", 4'h2, gpio_oe)
    ev(3, 1'b1);
    `CHK("gpio_out", 4'h0, gpio_out)
    `CHK("irq_seen", 1'b1, seen)
    ev(3, 1'b0);
    $display("t_all done");
  endtask : t_all

  task automatic t_lane;
    logic e;
    wr(deic_pkg::OFF_LANE_EN, 32'h0000_0001);
    for (int m = 0; m < 8; m++) begin
      wr(deic_pkg::OFF_LANE_SEL, 32'(m));
      for (int l = 0; l < 4; l++) begin
        wr(deic_pkg::OFF_CTRL, 32'h0000_0015);
        lane_events[l * 8] <= 1'b1;
        repeat (3) @(posedge clk);
        lane_events <= 32'h0000_0000;
        e = (m < 4) ? (l == m) : (m == 4) ? (l == 0 || l == 2) : (m == 5);
        rdr(deic_pkg::OFF_LANE_SUM);
        `CHK("summary", {31'h0, e}, rd)
        rdf();
        `CHK("lane flag", e, fl[0])
      end
    end
    // Disabled lane event type must not reach the summary
    wr(deic_pkg::OFF_LANE_SEL, 32'h0000_0000);
    wr(deic_pkg::OFF_CTRL, 32'h0000_0015);
    lane_events[1] <= 1'b1;
    repeat (3) @(posedge clk);
    lane_events <= 32'h0000_0000;
    rdr(deic_pkg::OFF_LANE_SUM);
    `CHK("summary", 32'h0000_0000, rd)
    rdr(deic_pkg::OFF_LANE_FLAGS);
    `CHK("lane flags", 32'h0101_0103, rd)
    wr(deic_pkg::OFF_LANE_RST, 32'h0000_0001);
    rdr(deic_pkg::OFF_LANE_FLAGS);
    `CHK("lane flags", 32'h0000_0000, rd)
    $display("t_lane done");
  endtask : t_lane

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_edge();
    t_all();
    t_lane();
    test_done();
  end

  // Whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule : test_dac_event_interrupt_controller
